// ### fan_cfg_defs.svh
// Purpose: Constants for the fan drive configuration block.
// Assumes: 100 MHz core clock.
// Notes:   Offsets, field positions, reset values and timing counts.
// How it works
// - Config bit 7 always reads zero.
// - Override set: table indexed by forced temperature.
// - Limits always use the measured temperature.
// - Override ignored unless table drives the fan.
// - Override clear: table indexed by measured temperature.
// - Program set: setting writable, drives output directly.
// - Program clear: setting read-only, table drives fan.
// - Polarity one inverts the drive output.
// - Polarity zero drives the output non-inverted.
// - Strap variant loads polarity from pin within 10ms.
// - Clock select: one 1.4 kHz, zero 360 kHz.
// - Divider override takes base from divide register.
// - Low two bits select tachometer reading mode.
// - Nonzero mode reports all ones below minimum.
// - 360 kHz base forces tachometer mode zero.
`ifndef FAN_CFG_DEFS_SVH
`define FAN_CFG_DEFS_SVH
`define FAN_CFG_ADDR   8'h4A
`define FAN_SET_ADDR   8'h4C
`define CFG_FORCE_BIT  6
`define CFG_BYPASS_BIT 5
`define CFG_POL_BIT    4
`define CFG_SEL_BIT    3
`define CFG_OVR_BIT    2
`define CFG_RST        7'h20
`define SET_RST        6'h00
`define TACH_ALL_ONES  16'hFFFF
`define TACH_MODE_RAW  2'b00
`define CLK_MHZ        100
`define STRAP_TIME_MS  10
`define STRAP_CYCLES   (`STRAP_TIME_MS * 1000 * `CLK_MHZ)
`endif

// ### fan_cfg_pkg.sv
// Purpose: Types shared by the fan drive configuration files.
// Assumes: Nothing beyond the defs header.
// Notes:   One-hot codes are written out.
package fan_cfg_pkg;
	typedef enum logic [2:0] {
		BASE_360K = 3'b001,
		BASE_1K4  = 3'b010,
		BASE_DIV  = 3'b100
	} base_clk_t;
	typedef enum logic [1:0] {
		ST_WAIT = 2'b01,
		ST_DONE = 2'b10
	} strap_st_t;
endpackage : fan_cfg_pkg

// ### fan_cfg_apply.sv
// Purpose: Holds the output-shaping fields until a PWM period ends.
// Assumes: period_end_i is a one-cycle pulse from the PWM counter.
// Notes:   Reset values match the configuration register reset.
`timescale 1ns/1ps
`include "fan_cfg_defs.svh"
module fan_cfg_apply (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	input  wire logic                  ce_i,
	// Period boundary and programmed fields
	input  wire logic                  period_end_i,
	input  wire logic                  pol_i,
	input  wire logic                  clk_sel_i,
	input  wire logic                  div_ovr_i,
	// Applied fields
	output logic                       pol_o,
	output fan_cfg_pkg::base_clk_t     base_o
);
	logic                   pol_q, pol_d;
	fan_cfg_pkg::base_clk_t base_q, base_d;

	always_comb begin
		pol_d  = pol_q;
		base_d = base_q;
		// Taking new fields mid-period would truncate the pulse.
		if (period_end_i) begin
			pol_d = pol_i;
			if (div_ovr_i) begin
				base_d = fan_cfg_pkg::BASE_DIV;
			end else if (clk_sel_i) begin
				base_d = fan_cfg_pkg::BASE_1K4;
			end else begin
				base_d = fan_cfg_pkg::BASE_360K;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pol_q  <= 1'b0;
			base_q <= fan_cfg_pkg::BASE_360K;
		end else if (ce_i) begin
			pol_q  <= pol_d;
			base_q <= base_d;
		end
	end

	assign pol_o  = pol_q;
	assign base_o = base_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_apply_hold_mid: assert property (!(ce_i && period_end_i) |=> $stable(pol_o) && $stable(base_o))
		else $error("Applied fields changed inside a period.");
	a_apply_div_wins: assert property (ce_i && period_end_i && div_ovr_i |=> base_o == fan_cfg_pkg::BASE_DIV)
		else $error("Divider override did not select the divide base.");
	a_apply_sel_map: assert property (ce_i && period_end_i && !div_ovr_i
		|=> base_o == ($past(clk_sel_i) ? fan_cfg_pkg::BASE_1K4 : fan_cfg_pkg::BASE_360K))
		else $error("Clock select mapped to the wrong base.");
endmodule : fan_cfg_apply

// ### fan_drive_configuration.sv
// Purpose: Fan configuration byte, fan setting byte and drive shaping.
// Assumes: Register port is the serial management slave's byte port.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/1ps
`include "fan_cfg_defs.svh"
module fan_drive_configuration #(
	parameter bit          STRAP_VARIANT = 1'b0,
	parameter int unsigned STRAP_CYCLES  = `STRAP_CYCLES,
	parameter int unsigned SET_W         = 6,
	parameter int unsigned TEMP_W        = 8
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	input  wire logic                  ce_i,
	// Register byte port
	input  wire logic [7:0]            addr_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	input  wire logic [7:0]            wdata_i,
	output logic      [7:0]            rdata_o,
	// Strap sense
	input  wire logic                  pin_a_i,
	// Temperatures
	input  wire logic [TEMP_W-1:0]     measured_temp_i,
	input  wire logic [TEMP_W-1:0]     forced_temp_i,
	output logic      [TEMP_W-1:0]     lut_index_temp_o,
	output logic      [TEMP_W-1:0]     limit_temp_o,
	// Look-up table
	input  wire logic [SET_W-1:0]      lut_drive_i,
	output logic                       lut_write_en_o,
	// Drive
	input  wire logic                  period_end_i,
	output logic      [SET_W-1:0]      drive_level_o,
	output fan_cfg_pkg::base_clk_t     base_clk_o,
	// Tachometer
	input  wire logic [15:0]           tach_count_i,
	input  wire logic [15:0]           tach_limit_i,
	output logic      [1:0]            tach_mode_eff_o,
	output logic      [15:0]           tach_reading_o
);
	localparam int unsigned CNT_W = 24;

	if (SET_W < 1 || SET_W > 8 || TEMP_W < 1 || TEMP_W > 16) begin : g_bad_width
		$error("Unsupported width.");
	end
	if (STRAP_CYCLES < 1 || STRAP_CYCLES >= (1 << CNT_W)) begin : g_bad_strap
		$error("Strap delay out of range.");
	end

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// ************************************************************
	// Register state
	// ************************************************************
	logic [6:0]             cfg_q, cfg_d;
	logic [SET_W-1:0]       set_q, set_d;
	logic [7:0]             rdata_q, rdata_d;
	fan_cfg_pkg::strap_st_t st_q, st_d;
	logic [CNT_W-1:0]       cnt_q, cnt_d;
	logic                   table_bypass_write_en, force_en, cfg_wr, set_wr, strap_hit;

	assign table_bypass_write_en = cfg_q[`CFG_BYPASS_BIT];
	assign force_en              = cfg_q[`CFG_FORCE_BIT];
	assign cfg_wr                = wr_i && hit(addr_i, `FAN_CFG_ADDR);
	assign set_wr                = wr_i && hit(addr_i, `FAN_SET_ADDR);
	assign strap_hit             = (st_q == fan_cfg_pkg::ST_WAIT)
		&& (cnt_q == CNT_W'(STRAP_CYCLES - 1));

	always_comb begin
		cfg_d = cfg_q;
		set_d = set_q;
		st_d  = st_q;
		cnt_d = cnt_q;
		unique case (st_q)
			fan_cfg_pkg::ST_WAIT: begin
				cnt_d = cnt_q + CNT_W'(1);
				if (strap_hit) begin
					st_d = fan_cfg_pkg::ST_DONE;
					// The pull-up is sampled once, well after power settles.
					if (STRAP_VARIANT) begin
						cfg_d[`CFG_POL_BIT] = pin_a_i;
					end
				end
			end
			fan_cfg_pkg::ST_DONE: begin
				cnt_d = cnt_q;
			end
		endcase
		// A host write in the strap sample cycle wins over the strap.
		if (cfg_wr) begin
			cfg_d = wdata_i[6:0];
		end
		if (table_bypass_write_en) begin
			if (set_wr) begin
				set_d = wdata_i[SET_W-1:0];
			end
		end else begin
			// Tracking keeps the last table value once programming is re-enabled.
			set_d = lut_drive_i;
		end
		rdata_d = rdata_q;
		if (rd_i) begin
			if (hit(addr_i, `FAN_CFG_ADDR)) begin
				rdata_d = {1'b0, cfg_q};
			end else if (hit(addr_i, `FAN_SET_ADDR)) begin
				rdata_d = 8'(set_q);
			end else begin
				rdata_d = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg_q   <= `CFG_RST;
			set_q   <= SET_W'(`SET_RST);
			rdata_q <= 8'h00;
			st_q    <= fan_cfg_pkg::ST_WAIT;
			cnt_q   <= '0;
		end else if (ce_i) begin
			cfg_q   <= cfg_d;
			set_q   <= set_d;
			rdata_q <= rdata_d;
			st_q    <= st_d;
			cnt_q   <= cnt_d;
		end
	end

	assign rdata_o        = rdata_q;
	assign lut_write_en_o = table_bypass_write_en;

	// ************************************************************
	// Temperature routing
	// ************************************************************
	// The forced value only matters while the table drives the fan.
	assign lut_index_temp_o = (force_en && !table_bypass_write_en)
		? forced_temp_i : measured_temp_i;
	assign limit_temp_o     = measured_temp_i;

	// ************************************************************
	// Drive shaping and tachometer
	// ************************************************************
	logic                   pol_app;
	fan_cfg_pkg::base_clk_t base_app;
	logic [SET_W-1:0]       drive_q, drive_d;
	logic [15:0]            tach_q, tach_d;
	logic [1:0]             mode_eff;

	fan_cfg_apply u_apply (
		.clk_i        (clk_i),
		.reset_n_i    (reset_n_i),
		.ce_i         (ce_i),
		.period_end_i (period_end_i),
		.pol_i        (cfg_q[`CFG_POL_BIT]),
		.clk_sel_i    (cfg_q[`CFG_SEL_BIT]),
		.div_ovr_i    (cfg_q[`CFG_OVR_BIT]),
		.pol_o        (pol_app),
		.base_o       (base_app)
	);

	always_comb begin
		// Full scale stays all ones, so inversion maps zero to maximum.
		drive_d  = pol_app ? ~set_q : set_q;
		// The low two bits pick the mode; the fast base clock cannot resolve slow fans.
		mode_eff = (base_app == fan_cfg_pkg::BASE_360K) ? `TACH_MODE_RAW : cfg_q[1:0];
		tach_d   = tach_count_i;
		if (mode_eff != `TACH_MODE_RAW && tach_count_i > tach_limit_i) begin
			tach_d = `TACH_ALL_ONES;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			drive_q <= '0;
			tach_q  <= `TACH_ALL_ONES;
		end else if (ce_i) begin
			drive_q <= drive_d;
			tach_q  <= tach_d;
		end
	end

	assign drive_level_o   = drive_q;
	assign base_clk_o      = base_app;
	assign tach_mode_eff_o = mode_eff;
	assign tach_reading_o  = tach_q;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_msb_reads_zero: assert property (ce_i && rd_i && hit(addr_i, `FAN_CFG_ADDR) |=> rdata_o[7] == 1'b0)
		else $error("Config bit 7 read nonzero.");
	a_lut_forced_idx: assert property (force_en && !table_bypass_write_en
		|-> lut_index_temp_o == forced_temp_i)
		else $error("Forced temperature not used for table index.");
	a_limit_measured: assert property (force_en |-> limit_temp_o == measured_temp_i)
		else $error("Limits compared against forced value.");
	a_force_ignored: assert property (table_bypass_write_en || !force_en
		|-> lut_index_temp_o == measured_temp_i)
		else $error("Override used while table inactive.");
	a_setting_write: assert property (ce_i && set_wr && table_bypass_write_en
		|=> set_q == $past(wdata_i[SET_W-1:0]))
		else $error("Fan setting write not taken.");
	a_setting_locked: assert property (ce_i && !table_bypass_write_en
		|=> set_q == $past(lut_drive_i))
		else $error("Fan setting not following the table.");
	a_drive_polarity: assert property (ce_i ##1 ce_i
		|-> drive_level_o == ($past(pol_app) ? ~$past(set_q) : $past(set_q)))
		else $error("Drive polarity wrong.");
	a_tach_all_ones: assert property (ce_i && mode_eff != 2'b00
		&& tach_count_i > tach_limit_i |=> tach_reading_o == 16'hFFFF)
		else $error("Slow fan not reported as all ones.");
	a_tach_fast_raw: assert property (base_clk_o == fan_cfg_pkg::BASE_360K |-> tach_mode_eff_o == 2'b00)
		else $error("Tach mode not forced under fast base clock.");
	a_strap_window: assert property (st_q == fan_cfg_pkg::ST_WAIT |-> cnt_q < CNT_W'(STRAP_CYCLES))
		else $error("Strap sample missed its window.");

	c_table_forced:  cover property (force_en && !table_bypass_write_en);
	c_inverted_out:  cover property (pol_app && set_q == '0);
	c_tach_clamped:  cover property (tach_reading_o == 16'hFFFF && mode_eff != 2'b00);
	c_strap_done:    cover property (strap_hit && ce_i);
endmodule : fan_drive_configuration

// ### host_model.sv
// Purpose: Host side of the register byte port, one byte per transfer.
// Assumes: Strobes are launched at the falling clock edge.
// Notes:   Released address and data lines show inverted values and strobes drop low, so stale data never looks valid.
`timescale 1ns/1ps
module host_model (
	// Clock
	input  wire logic       clk_i,
	// Register byte port
	output logic      [7:0] addr_o,
	output logic            wr_o,
	output logic            rd_o,
	output logic      [7:0] wdata_o,
	input  wire logic [7:0] rdata_i
);
	// ****
	// Byte transfers
	// ****
	initial begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = w;
		rd_o = !w;
		@(negedge clk_i);
		q = rdata_i;
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask : xfer
endmodule : host_model

// ### fan_drive_configuration_tb.sv
// Purpose: Self-checking bench for the fan drive configuration block.
// Assumes: Strap count shortened to 20 cycles, strap pin high, then low for a second reset.
// Notes:   Expected values come from the bench's own model of the fields.
`timescale 1ns/1ps
`include "fan_cfg_defs.svh"
module fan_drive_configuration_tb;
	logic                   clk_i = 1'b0;
	logic                   reset_n = 1'b0;
	logic [7:0]             addr, wdata, rdata, mt, ft, lit, lim, q, e_cfg;
	logic                   wr, rd, lwe, a_pol, pe = 1'b0;
	logic                   ce = 1'b1, pin = 1'b1;
	logic [5:0]             lutd = 6'h00, drv, e_set;
	logic [15:0]            tc = 16'h0000, tl = 16'h0000, tr;
	logic [1:0]             tme;
	fan_cfg_pkg::base_clk_t base, a_base;
	int                     n_mismatch = 0, n_checks = 0;
	logic [7:0]             corner [6] = '{8'h24, 8'h08, 8'h00, 8'h50, 8'h13, 8'h7F};
	initial begin
		mt = 8'h00;
		ft = 8'h00;
	end
	always #5 clk_i = ~clk_i;
	fan_drive_configuration #(.STRAP_VARIANT(1'b1), .STRAP_CYCLES(20)) i_dut (
		.clk_i(clk_i), .reset_n_i(reset_n), .ce_i(ce), .addr_i(addr), .wr_i(wr),
		.rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .pin_a_i(pin),
		.measured_temp_i(mt), .forced_temp_i(ft), .lut_index_temp_o(lit),
		.limit_temp_o(lim), .lut_drive_i(lutd), .lut_write_en_o(lwe),
		.period_end_i(pe), .drive_level_o(drv), .base_clk_o(base),
		.tach_count_i(tc), .tach_limit_i(tl), .tach_mode_eff_o(tme),
		.tach_reading_o(tr));
	host_model i_host (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd),
		.wdata_o(wdata), .rdata_i(rdata));
	// ****
	// Checking
	// ****
	task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk_reg
	task automatic chk_out(input string n, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk_out
	function automatic fan_cfg_pkg::base_clk_t base_of(input logic [7:0] c);
		if (c[`CFG_OVR_BIT]) return fan_cfg_pkg::BASE_DIV;
		return c[`CFG_SEL_BIT] ? fan_cfg_pkg::BASE_1K4 : fan_cfg_pkg::BASE_360K;
	endfunction : base_of
	function automatic logic [15:0] tach_of(input logic [1:0] m);
		return (m != 2'b00 && tc > tl) ? `TACH_ALL_ONES : tc;
	endfunction : tach_of
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	// ****
	// One configuration step: write, read back, then apply at a boundary
	// ****
	task automatic step(input logic [7:0] r);
		logic [7:0] s;
		logic [1:0] m;
		logic [5:0] e_drv;
		s = 8'($urandom);
		mt = 8'($urandom);
		ft = 8'($urandom);
		lutd = 6'($urandom);
		tc = 16'($urandom);
		tl = 16'($urandom);
		i_host.xfer(1'b1, `FAN_CFG_ADDR, r, q);
		e_cfg = r & 8'h7F;
		chk_out("base_hold", a_base, base);
		chk_out("index", (e_cfg[6] && !e_cfg[5]) ? ft : mt, lit);
		chk_out("limit", mt, lim);
		chk_out("write_en", e_cfg[5], lwe);
		i_host.xfer(1'b1, `FAN_SET_ADDR, s, q);
		e_set = e_cfg[5] ? s[5:0] : lutd;
		i_host.xfer(1'b0, `FAN_SET_ADDR, 8'h00, q);
		chk_reg("setting", {2'b00, e_set}, q);
		i_host.xfer(1'b0, `FAN_CFG_ADDR, 8'h00, q);
		chk_reg("config", e_cfg, q);
		@(negedge clk_i);
		pe = 1'b1;
		@(negedge clk_i);
		pe = 1'b0;
		a_pol = e_cfg[4];
		a_base = base_of(e_cfg);
		m = (a_base == fan_cfg_pkg::BASE_360K) ? 2'b00 : e_cfg[1:0];
		repeat (2) @(negedge clk_i);
		chk_out("base", a_base, base);
		e_drv = a_pol ? ~e_set : e_set;
		chk_out("drive", e_drv, drv);
		chk_out("tach_mode", m, tme);
		chk_out("tach", tach_of(m), tr);
	endtask : step
	// ****
	// Main sequence
	// ****
	initial begin
		void'($urandom(93677));
		a_pol = 1'b0;
		a_base = fan_cfg_pkg::BASE_360K;
		repeat (16) @(negedge clk_i);
		chk_out("rst_base", fan_cfg_pkg::BASE_360K, base);
		chk_out("rst_drive", 16'h0000, drv);
		chk_out("rst_write_en", 1'b1, lwe);
		reset_n = 1'b1;
		i_host.xfer(1'b0, `FAN_CFG_ADDR, 8'h00, q);
		chk_reg("rst_config", 8'h20, q);
		repeat (25) @(negedge clk_i);
		i_host.xfer(1'b0, `FAN_CFG_ADDR, 8'h00, q);
		chk_reg("strap_config", 8'h30, q);
		e_cfg = 8'h30;
		i_host.xfer(1'b1, 8'h4B, 8'hFF, q);
		i_host.xfer(1'b0, 8'h4B, 8'h00, q);
		chk_reg("unmapped", 8'h00, q);
		i_host.xfer(1'b0, `FAN_CFG_ADDR, 8'h00, q);
		chk_reg("config_kept", e_cfg, q);
		ce = 1'b0;
		i_host.xfer(1'b1, `FAN_CFG_ADDR, 8'h00, q);
		ce = 1'b1;
		i_host.xfer(1'b0, `FAN_CFG_ADDR, 8'h00, q);
		chk_reg("ce_frozen", e_cfg, q);
		step(8'hFF);
		for (int i = 0; i < 46; i++) step(i < 6 ? corner[i] : 8'($urandom));
		@(negedge clk_i);
		reset_n = 1'b0;
		pin = 1'b0;
		a_pol = 1'b0;
		a_base = fan_cfg_pkg::BASE_360K;
		repeat (2) @(negedge clk_i);
		chk_out("rst2_base", fan_cfg_pkg::BASE_360K, base);
		chk_out("rst2_tach_mode", 16'h0000, tme);
		reset_n = 1'b1;
		i_host.xfer(1'b1, `FAN_CFG_ADDR, 8'h30, q);
		repeat (25) @(negedge clk_i);
		i_host.xfer(1'b0, `FAN_CFG_ADDR, 8'h00, q);
		chk_reg("strap_low", 8'h20, q);
		for (int i = 0; i < 3; i++) step(8'($urandom));
		tally_and_finish();
	end
	initial begin
		#200000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule : fan_drive_configuration_tb
